// >>> bvpgs_consts.vh
// constants for the boot code and power-good sequencer
`ifndef BVPGS_CONSTS_VH
`define BVPGS_CONSTS_VH
`define BVPGS_CLK_MHZ 100
`define BVPGS_BLANK_US 20
`define BVPGS_BLANK_CYC (`BVPGS_BLANK_US * `BVPGS_CLK_MHZ)
`define BVPGS_CNT_W 12
`define BVPGS_VID_W 8
`define BVPGS_BOOT_W 2
`define BVPGS_NCONV 3
`define BVPGS_DISCH_OHM 20
`define BVPGS_ST_OFF 3'h0
`define BVPGS_ST_RAMP 3'h1
`define BVPGS_ST_DELAY 3'h2
`define BVPGS_ST_ACTIVE 3'h3
`define BVPGS_ST_FALLBACK 3'h4
`endif

// >>> bvpgs_host_model.sv
// processor and system side: boot bits and system power good
`timescale 1ns/1ps
module bvpgs_host_model (
  // clock
  input wire clk_in,
  // device pins and test control
  input wire shutdown_n_in,
  input wire pin_level_in,
  input wire [1:0] boot_in,
  input wire drop_in,
  // driven pins
  output reg system_power_good_out,
  output wire vid_clock_out,
  output wire vid_data_out
);
  reg [3:0] wait_reg;
  initial system_power_good_out = 1'b0;
  initial wait_reg = 4'h0;
  assign vid_clock_out = boot_in[1];
  assign vid_data_out = boot_in[0];
  always @(posedge clk_in) begin
    if (!shutdown_n_in || !pin_level_in)
      wait_reg <= 4'h0;
    else if (wait_reg != 4'hF)
      wait_reg <= wait_reg + 4'h1;
    system_power_good_out <= shutdown_n_in && !drop_in &&
      (system_power_good_out || wait_reg == 4'hF);
  end
endmodule

// >>> bvpgs_props.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
`include "bvpgs_consts.vh"
module bvpgs_props (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // inputs watched
  input wire shutdown_n_in,
  input wire system_power_good_in,
  input wire [`BVPGS_NCONV-1:0] conv_skip_mode_in,
  input wire slew_active_in,
  input wire overvoltage_in,
  input wire zero_cross_2_in,
  // outputs watched
  input wire [`BVPGS_BOOT_W-1:0] boot_code_out,
  input wire boot_stored_out,
  input wire svi_active_out,
  input wire power_good_oe_out,
  input wire low_side_gate_2_out,
  input wire high_side_gate_2_out,
  input wire discharge_2_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_slew_good_release: assert property (
    slew_active_in |-> !power_good_oe_out) else $error("good not released");
  a_shutdown_n_gates_low: assert property (
    !shutdown_n_in [*5] |-> !low_side_gate_2_out && !high_side_gate_2_out)
    else $error("gate high in shutdown");
  a_shutdown_n_discharge_on: assert property (
    !shutdown_n_in [*5] |-> discharge_2_out) else $error("discharge off");
  a_shutdown_n_good_low: assert property (
    !shutdown_n_in [*5] ##0 !slew_active_in |-> power_good_oe_out)
    else $error("good not low in shutdown");
  a_ov_low_high: assert property (
    (shutdown_n_in && overvoltage_in) [*5] |-> low_side_gate_2_out)
    else $error("low side not forced high");
  a_zero_cross_low: assert property (
    (shutdown_n_in && !overvoltage_in && zero_cross_2_in &&
    conv_skip_mode_in[1]) [*5] |-> !low_side_gate_2_out)
    else $error("low side not forced low");
  a_svi_needs_good: assert property (
    svi_active_out |-> $past(system_power_good_in, 2) ||
    $past(system_power_good_in, 3)) else $error("svi active early");
  a_boot_code_kept: assert property (
    boot_stored_out && $past(boot_stored_out) |-> $stable(boot_code_out))
    else $error("stored code moved");
endmodule
bind bvpgs_sequencer bvpgs_props u_props (.*);

// >>> bvpgs_sequencer.v
// boot code, power-good and gate override sequencer
// Operation
// - decode boot bits until good rises; in the hold-off only while system good low
// - system good high enables serial commands
// - latch boot code at first good rise
// - clear stored boot code on shutdown release
// - system good fall returns to boot code
// - fallback uses normal transition blanking
// - later system good rise keeps stored code
// - one good output combines three converters
// - good released during any slew
// - good held low 20us after boot reached
// - good driven low in shutdown
// - skip mode blanks upper comparator downward
// - blank removed once back in regulation
// - converter 2 gates low in shutdown
// - overvoltage forces low-side gate high
// - skip zero crossing forces low-side low
// - discharge switch on when converter 2 off
`timescale 1ns/1ps
`include "bvpgs_consts.vh"

module bvpgs_sequencer (
  // clock and reset (reset_in is a synchronous reset, active high; the shutdown level comes in on shutdown_n_in)
  input wire clk_in,
  input wire reset_in,
  // pins from processor and system
  input wire shutdown_n_in,
  input wire system_power_good_in,
  input wire serial_vid_clock_in,
  input wire serial_vid_data_in,
  // serial command decoded elsewhere
  input wire vid_cmd_valid_in,
  input wire [`BVPGS_VID_W-1:0] vid_cmd_code_in,
  // analog status, one bit per converter, and one slew flag shared by all
  input wire [`BVPGS_NCONV-1:0] conv_in_reg_in,
  input wire [`BVPGS_NCONV-1:0] conv_upper_trip_in,
  input wire [`BVPGS_NCONV-1:0] conv_lower_ok_in,
  input wire [`BVPGS_NCONV-1:0] conv_skip_mode_in,
  input wire slew_active_in,
  // converter 2 requests from the modulator
  input wire overvoltage_in,
  input wire zero_cross_2_in,
  input wire low_side_req_2_in,
  input wire high_side_req_2_in,
  // target code and status
  output reg [`BVPGS_VID_W-1:0] target_vid_out,
  output reg [`BVPGS_BOOT_W-1:0] boot_code_out,
  output reg boot_stored_out,
  output reg svi_active_out,
  output reg fallback_out,
  output reg [`BVPGS_NCONV-1:0] upper_blank_out,
  // open-drain power good, low while enable high
  output wire power_good_out,
  output wire power_good_oe_out,
  // converter 2 drivers
  output reg low_side_gate_2_out,
  output reg high_side_gate_2_out,
  output reg discharge_2_out
);
  // hold-off count kept as an integer, then cut to the counter width
  localparam integer BLANK_INT = `BVPGS_BLANK_CYC;
  localparam [`BVPGS_CNT_W-1:0] BLANK_CYC = BLANK_INT[`BVPGS_CNT_W-1:0];
  localparam [2:0] ST_OFF = `BVPGS_ST_OFF;
  localparam [2:0] ST_RAMP = `BVPGS_ST_RAMP;
  localparam [2:0] ST_DELAY = `BVPGS_ST_DELAY;
  localparam [2:0] ST_ACTIVE = `BVPGS_ST_ACTIVE;
  localparam [2:0] ST_FALLBACK = `BVPGS_ST_FALLBACK;

  // pin images after the synchroniser
  wire [3:0] pins_sync;
  wire shutdown_n_n_s;
  wire shutdown_n_rise;
  wire good_rise;
  wire code_down;
  wire any_conv_bad;
  wire hold_low;
  wire sys_good_s;
  wire [`BVPGS_BOOT_W-1:0] boot_bits_s;

  // sequence and hold-off state
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`BVPGS_CNT_W-1:0] cnt_reg;
  reg [`BVPGS_CNT_W-1:0] cnt_next;
  reg shutdown_n_n_d_reg;
  reg sys_good_d_reg;
  reg sys_seen_reg;
  reg good_reg;
  reg good_next;
  reg good_d_reg;
  reg [`BVPGS_VID_W-1:0] prev_vid_reg;
  reg [`BVPGS_NCONV-1:0] upper_ok;
  integer i;
  integer j;

  // every pin crosses two flops; nothing reads the first stage
  bvpgs_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .d_in({shutdown_n_in, system_power_good_in, serial_vid_clock_in,
      serial_vid_data_in}),
    .q_out(pins_sync)
  );
  assign shutdown_n_n_s = pins_sync[3];
  assign sys_good_s = pins_sync[2];
  assign boot_bits_s = pins_sync[1:0];

  // boot bits map to a target code; simple linear placement
  function [`BVPGS_VID_W-1:0] boot_vid;
    input [`BVPGS_BOOT_W-1:0] b;
    begin
      boot_vid = {{(`BVPGS_VID_W-`BVPGS_BOOT_W){1'b0}}, b};
    end
  endfunction

  // one-cycle rise of a level against its delayed copy
  function rise_of;
    input now_v;
    input was_v;
    begin
      rise_of = now_v && !was_v;
    end
  endfunction

  assign shutdown_n_rise = rise_of(shutdown_n_n_s, shutdown_n_n_d_reg);
  assign good_rise = rise_of(good_reg, good_d_reg);
  // any fall of the target code is a downward move
  assign code_down = (target_vid_out < prev_vid_reg);

  // sequence state
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    good_next = good_reg;
    case (state_reg)
      ST_OFF: begin
        good_next = 1'b0;
        if (shutdown_n_n_s) begin
          state_next = ST_RAMP;
        end
      end
      ST_RAMP: begin
        // all three in window with no slew counts as boot reached
        if (!slew_active_in && (&conv_in_reg_in)) begin
          state_next = ST_DELAY;
          cnt_next = {`BVPGS_CNT_W{1'b0}};
        end
      end
      ST_DELAY: begin
        // hold off 20us
        // counter stops at the end value; no wrap past it
        if (cnt_reg == BLANK_CYC - 12'h001) begin
          state_next = ST_ACTIVE;
          good_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
      ST_ACTIVE: begin
        if (sys_seen_reg && sys_good_d_reg && !sys_good_s) begin
          state_next = ST_FALLBACK;
        end
      end
      ST_FALLBACK: begin
        if (sys_good_s) begin
          state_next = ST_ACTIVE;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // shutdown overrides every state, whatever the pins say
    if (!shutdown_n_n_s) begin
      state_next = ST_OFF;
      good_next = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= ST_OFF;
      cnt_reg <= {`BVPGS_CNT_W{1'b0}};
      good_reg <= 1'b0;
      good_d_reg <= 1'b0;
      shutdown_n_n_d_reg <= 1'b0;
      sys_good_d_reg <= 1'b0;
      sys_seen_reg <= 1'b0;
      boot_code_out <= {`BVPGS_BOOT_W{1'b0}};
      boot_stored_out <= 1'b0;
      target_vid_out <= {`BVPGS_VID_W{1'b0}};
      prev_vid_reg <= {`BVPGS_VID_W{1'b0}};
      svi_active_out <= 1'b0;
      fallback_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      good_reg <= good_next;
      good_d_reg <= good_reg;
      shutdown_n_n_d_reg <= shutdown_n_n_s;
      sys_good_d_reg <= sys_good_s;
      prev_vid_reg <= target_vid_out;
      fallback_out <= (state_next == ST_FALLBACK);
      if (state_reg != ST_OFF && sys_good_s) begin
        sys_seen_reg <= 1'b1;
      end

      if (shutdown_n_rise) begin
        boot_code_out <= {`BVPGS_BOOT_W{1'b0}};
        boot_stored_out <= 1'b0;
        sys_seen_reg <= 1'b0;
      end else if (good_rise && !boot_stored_out) begin
        // latch at first rise; not again until shutdown release clears it
        boot_stored_out <= 1'b1;
        boot_code_out <= boot_bits_s;
      end

      // serial commands only while system good
      svi_active_out <= sys_good_s && (state_reg == ST_ACTIVE);
      if (state_reg == ST_OFF || state_reg == ST_RAMP ||
          (state_reg == ST_DELAY && !sys_good_s)) begin
        // follow boot bits in off and ramp, and in the hold-off before system good
        target_vid_out <= boot_vid(boot_bits_s);
      end else if (state_reg == ST_FALLBACK) begin
        target_vid_out <= boot_vid(boot_code_out);
      end else if (svi_active_out && vid_cmd_valid_in) begin
        target_vid_out <= vid_cmd_code_in;
      end
    end
  end

  // per-converter blanking of the upper window comparator
  always @(posedge clk_in) begin
    if (reset_in) begin
      upper_blank_out <= {`BVPGS_NCONV{1'b0}};
    end else begin
      for (i = 0; i < `BVPGS_NCONV; i = i + 1) begin
        if (!shutdown_n_n_s) begin
          upper_blank_out[i] <= 1'b0;
        end else if (conv_skip_mode_in[i] && code_down) begin
          upper_blank_out[i] <= 1'b1;
        end else if (conv_in_reg_in[i] && !slew_active_in) begin
          // clear only once settled, else a late overshoot trips
          upper_blank_out[i] <= 1'b0;
        end
      end
    end
  end

  always @* begin
    for (j = 0; j < `BVPGS_NCONV; j = j + 1) begin
      upper_ok[j] = conv_lower_ok_in[j] &&
        (upper_blank_out[j] || !conv_upper_trip_in[j]);
    end
  end

  // one converter out of its window pulls the shared pin
  assign any_conv_bad = !(&upper_ok);

  // shutdown and the startup hold-off both force the pin low
  assign hold_low = !good_reg || !shutdown_n_n_s;

  // a slew releases the pin, whatever else is pending
  assign power_good_oe_out = !slew_active_in && (hold_low || any_conv_bad);

  // open drain: the pad only ever sinks, so the data bit stays low
  assign power_good_out = 1'b0;

  // converter 2 gate overrides
  always @(posedge clk_in) begin
    if (reset_in) begin
      low_side_gate_2_out <= 1'b0;
      high_side_gate_2_out <= 1'b0;
      discharge_2_out <= 1'b1;
    end else begin
      discharge_2_out <= !shutdown_n_n_s;

      if (!shutdown_n_n_s) begin
        low_side_gate_2_out <= 1'b0;
        high_side_gate_2_out <= 1'b0;
      end else if (overvoltage_in) begin
        // crowbar low side
        // outranks skip: a crowbar must not be cut short
        low_side_gate_2_out <= 1'b1;
        high_side_gate_2_out <= 1'b0;
      end else if (conv_skip_mode_in[1] && zero_cross_2_in) begin
        low_side_gate_2_out <= 1'b0;
        high_side_gate_2_out <= high_side_req_2_in;
      end else begin
        low_side_gate_2_out <= low_side_req_2_in;
        high_side_gate_2_out <= high_side_req_2_in;
      end
    end
  end
endmodule

// >>> bvpgs_sync.v
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module bvpgs_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // data
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_reg;
  always @(posedge clk_in) begin
    if (reset_in) begin
      meta_reg <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
`include "bvpgs_consts.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
  reg clk_in = 0, reset_in = 1, shutdown_n = 0, cmd_v = 0, slew = 0, drop = 0;
  reg ov = 0, zc = 0, lreq = 0, hreq = 0;
  reg [7:0] cmd = 8'h00;
  reg [2:0] inreg = 3'h7, utrip = 3'h0, lok = 3'h7, skip = 3'h0;
  reg [1:0] boot = 2'h2;
  wire pg, serial_vid_clock, serial_vid_data, pgo, pgoe, dl, dh, dis, stored, serial_vid_interface, fb;
  wire [7:0] tgt;
  wire [1:0] bc;
  wire [2:0] blank;
  integer fail_count = 0, n_tests = 0, cyc = 0, i;
  always #5 clk_in = ~clk_in;
  bvpgs_sequencer uut (.clk_in(clk_in), .reset_in(reset_in),
    .shutdown_n_in(shutdown_n), .system_power_good_in(pg),
    .serial_vid_clock_in(serial_vid_clock), .serial_vid_data_in(serial_vid_data),
    .vid_cmd_valid_in(cmd_v), .vid_cmd_code_in(cmd),
    .conv_in_reg_in(inreg), .conv_upper_trip_in(utrip),
    .conv_lower_ok_in(lok), .conv_skip_mode_in(skip),
    .slew_active_in(slew), .overvoltage_in(ov), .zero_cross_2_in(zc),
    .low_side_req_2_in(lreq), .high_side_req_2_in(hreq),
    .target_vid_out(tgt), .boot_code_out(bc), .boot_stored_out(stored),
    .svi_active_out(serial_vid_interface), .fallback_out(fb), .upper_blank_out(blank),
    .power_good_out(pgo), .power_good_oe_out(pgoe),
    .low_side_gate_2_out(dl), .high_side_gate_2_out(dh),
    .discharge_2_out(dis));
  // pull-up on the open-drain good pin
  bvpgs_host_model host (.clk_in(clk_in), .shutdown_n_in(shutdown_n),
    .pin_level_in(pgoe ? pgo : 1'b1), .boot_in(boot), .drop_in(drop),
    .system_power_good_out(pg), .vid_clock_out(serial_vid_clock), .vid_data_out(serial_vid_data));
  task give_verdict;
    begin
      $display("checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    tick(5);
    reset_in <= 0;
    tick(8);
    `CHK({dl, dh, dis, pgoe}, 4'h3)
    slew <= 1;
    shutdown_n <= 1;
    tick(6);
    boot <= 2'h1;
    tick(6);
    `CHK({pgoe, tgt}, 9'h001)
    slew <= 0;
    i = 0;
    while (stored !== 1'b1 && i < 2100) begin
      tick(1);
      i++;
    end
    `CHK(i >= 2000 && i < 2010, 1'b1)
    `CHK({bc, pgoe}, 3'h2)
    tick(24);
    `CHK(serial_vid_interface, 1'b1)
    cmd <= 8'h30;
    cmd_v <= 1;
    tick(1);
    cmd_v <= 0;
    inreg <= 3'h5;
    lok <= 3'h5;
    tick(3);
    `CHK({tgt, pgoe}, 9'h061)
    skip <= 3'h2;
    cmd <= 8'h10;
    cmd_v <= 1;
    tick(1);
    cmd_v <= 0;
    tick(3);
    `CHK(blank, 3'h2)
    inreg <= 3'h7;
    lok <= 3'h7;
    tick(3);
    `CHK({blank, pgoe}, 4'h0)
    drop <= 1;
    slew <= 1;
    tick(6);
    `CHK({fb, tgt, pgoe}, 10'h202)
    drop <= 0;
    slew <= 0;
    boot <= 2'h3;
    tick(30);
    `CHK({serial_vid_interface, bc}, 3'h5)
    lreq <= 1;
    hreq <= 1;
    ov <= 1;
    tick(6);
    `CHK(dl, 1'b1)
    ov <= 0;
    zc <= 1;
    tick(6);
    `CHK(dl, 1'b0)
    shutdown_n <= 0;
    tick(6);
    `CHK({dl, dh, dis, pgoe}, 4'h3)
    shutdown_n <= 1;
    slew <= 1;
    tick(6);
    `CHK({stored, bc}, 3'h0)
    give_verdict();
  end
endmodule
